// File: core/fcsir_en_field.sv
// One two-bit interrupt enable field with read codes 0h/2h and write codes 1h/3h.
`timescale 1ns/1ps
`default_nettype none
module fcsir_en_field (
  input  wire logic       core_clk,   // Core clock.
  input  wire logic       rst_n,      // Asynchronous reset, active low.
  input  wire logic       wr_stb,     // Write strobe for this field.
  input  wire logic [1:0] wr_code,    // Written field code.
  output var  logic       en_q,       // Current enable state.
  output logic      [1:0] rd_code     // Read-back code.
);
  import fcsir_pkg::*;

  // Only the codes 1h and 3h act, so fields not meant to change stay put.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_q <= 1'b1;
    end else if (wr_stb && wr_code == FCSIR_EN_WR_ON) begin
      en_q <= 1'b1;
    end else if (wr_stb && wr_code == FCSIR_EN_WR_OFF) begin
      en_q <= 1'b0;
    end
  end

  assign rd_code = en_q ? FCSIR_EN_RD_ON : FCSIR_EN_RD_OFF;

  a_code_holds: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr_stb && !wr_code[0]) |=> $stable(en_q))
    else $error("Enable changed on a write code with bit 0 clear.");
  a_code_acts: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr_stb && wr_code[0]) |=> (en_q == $past(wr_code[1])))
    else $error("Enable did not follow write code 1h or 3h.");

endmodule : fcsir_en_field
`default_nettype wire

// File: core/fcsir_pkg.sv
// Package of register offsets, field positions, reset values and codes for the fault and supply interrupt block.
package fcsir_pkg;

  // Register word indices; each register sits at four times its printed offset, so printed offsets are indices.
  localparam logic [3:0]  FCSIR_IDX_FAULT_CFG  = 4'h6;
  localparam logic [3:0]  FCSIR_IDX_SUPPLY_EN  = 4'h8;
  localparam logic [3:0]  FCSIR_IDX_GLOBAL_EN  = 4'hC;
  localparam logic [3:0]  FCSIR_IDX_IRQ_STAT   = 4'hD;
  localparam logic [3:0]  FCSIR_IDX_IRQ_MASK   = 4'hE;
  localparam int          FCSIR_ADDR_W         = 8;

  // Reset values.
  localparam logic [15:0] FCSIR_FAULT_CFG_RST  = 16'h0100;
  localparam logic [15:0] FCSIR_SUPPLY_EN_RST  = 16'h2AAA;
  localparam logic [15:0] FCSIR_GLOBAL_EN_RST  = 16'h0080;
  localparam logic [6:0]  FCSIR_IRQ_MASK_RST   = 7'h7F;

  // Field positions.
  localparam int          FCSIR_GND_DET_BIT    = 8;
  localparam int          FCSIR_STRINGS        = 4;
  localparam int          FCSIR_SRC_NUM        = 7;
  localparam int          FCSIR_GLOBAL_LSB     = 6;

  // Two-bit enable codes.
  localparam logic [1:0]  FCSIR_EN_RD_OFF      = 2'h0;
  localparam logic [1:0]  FCSIR_EN_RD_ON       = 2'h2;
  localparam logic [1:0]  FCSIR_EN_WR_OFF      = 2'h1;
  localparam logic [1:0]  FCSIR_EN_WR_ON       = 2'h3;

endpackage : fcsir_pkg

// File: core/fcsir_regs.sv
// Fault detection configuration and supply interrupt enable registers behind an APB slave.
// What this block does
// - Ground short detection on while bit 8 set
// - Per-string short fault suppressed by its bit
// - Enable fields read 2h on, 0h off
// - Write 1h disables, 3h enables
// - Bits 13-12 enable missing boost sync
// - Bits 11-10 enable charge pump fault
// - Bits 9-8 enable missing pump capacitor
// - Resets 100h and 2AAAh, upper bits zero
// - Global two-bit enable gates every source
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module fcsir_regs #(
  parameter int ADDR_W = fcsir_pkg::FCSIR_ADDR_W                   // APB address width.
) (
  input  wire logic                                   core_clk,       // Core clock, 200 MHz.
  input  wire logic                                   rst_n,          // Asynchronous reset, active low.
  input  wire logic                                   psel,           // APB select.
  input  wire logic                                   penable,        // APB access phase.
  input  wire logic                                   pwrite,         // APB write.
  input  wire logic [ADDR_W-1:0]                      paddr,          // APB byte address.
  input  wire logic [31:0]                            pwdata,         // APB write data.
  input  wire logic [3:0]                             pstrb,          // APB byte strobes.
  output logic                                        pready,         // APB ready, always high.
  output logic      [31:0]                            prdata,         // APB read data.
  output logic                                        pslverr,        // APB error on unmapped address.
  input  wire logic [fcsir_pkg::FCSIR_SRC_NUM-1:0]    supply_fault,   // Raw supply fault detects.
  input  wire logic [fcsir_pkg::FCSIR_STRINGS-1:0]    string_short,   // Raw internal string shorts.
  input  wire logic                                   gnd_short_raw,  // Raw LED ground short detect.
  input  wire logic                                   boost_active,   // Boost soft-start or normal stage.
  output logic      [fcsir_pkg::FCSIR_STRINGS-1:0]    string_fault,   // Reported string short faults.
  output logic                                        gnd_short,      // Reported ground short fault.
  output logic                                        irq             // Level interrupt output.
);
  import fcsir_pkg::*;

  logic [15:0]              cfg_q;
  logic [FCSIR_SRC_NUM-1:0] src_en;
  logic [13:0]              src_rd;
  logic                     glb_en;
  logic [1:0]               glb_rd;
  logic [FCSIR_SRC_NUM-1:0] stat_q;
  logic [FCSIR_SRC_NUM-1:0] mask_q;
  logic [FCSIR_SRC_NUM-1:0] src_evt;
  logic                     acc;
  logic                     wr_acc;
  logic [3:0]               idx;
  logic                     hit;
  logic                     lo_wr;
  logic                     hi_wr;

  // Word index decode; registers take one aligned word each at four times the printed offset.
  function automatic logic [3:0] fcsir_index(input logic [ADDR_W-1:0] a);
    fcsir_index = a[5:2];
  endfunction : fcsir_index

  function automatic logic fcsir_mapped(input logic [3:0] i);
    fcsir_mapped = (i == FCSIR_IDX_FAULT_CFG) || (i == FCSIR_IDX_SUPPLY_EN) ||
                   (i == FCSIR_IDX_GLOBAL_EN) || (i == FCSIR_IDX_IRQ_STAT) || (i == FCSIR_IDX_IRQ_MASK);
  endfunction : fcsir_mapped

  // Zero-wait slave: every access completes in its first access cycle.
  assign acc     = psel && penable;
  assign idx     = fcsir_index(paddr);
  assign hit     = fcsir_mapped(idx) && (paddr[ADDR_W-1:6] == '0) && (paddr[1:0] == 2'h0);
  assign wr_acc  = acc && pwrite && hit;
  assign lo_wr   = wr_acc && pstrb[0];
  assign hi_wr   = wr_acc && pstrb[1];
  assign pready  = 1'b1;
  assign pslverr = acc && !hit;

  // Fault configuration; reserved bits 15-9 read zero, bits 7-4 store what software writes.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= FCSIR_FAULT_CFG_RST;
    end else if (idx == FCSIR_IDX_FAULT_CFG) begin
      if (lo_wr) begin
        cfg_q[7:0] <= pwdata[7:0];
      end
      if (hi_wr) begin
        cfg_q[FCSIR_GND_DET_BIT] <= pwdata[FCSIR_GND_DET_BIT];
      end
    end
  end

  // Seven supply enable fields, bits 13-0, low field is input undervoltage.
  generate
    for (genvar g = 0; g < FCSIR_SRC_NUM; g++) begin : g_src
      logic fld_wr;
      assign fld_wr = (idx == FCSIR_IDX_SUPPLY_EN) && (g < 4 ? lo_wr : hi_wr);
      fcsir_en_field u_fld (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .wr_stb   (fld_wr),
        .wr_code  (pwdata[2*g+1 -: 2]),
        .en_q     (src_en[g]),
        .rd_code  (src_rd[2*g+1 -: 2])
      );
    end
  endgenerate

  // Global enable in bits 7-6 of its own word.
  fcsir_en_field u_glb (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .wr_stb   ((idx == FCSIR_IDX_GLOBAL_EN) && lo_wr),
    .wr_code  (pwdata[FCSIR_GLOBAL_LSB+1:FCSIR_GLOBAL_LSB]),
    .en_q     (glb_en),
    .rd_code  (glb_rd)
  );

  // A source latches only while both its own and the global enable are on.
  assign src_evt = supply_fault & src_en & {FCSIR_SRC_NUM{glb_en}};

  // Sticky status, write one to clear; a new event in the clearing cycle wins.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_q <= '0;
    end else if (idx == FCSIR_IDX_IRQ_STAT && lo_wr) begin
      stat_q <= (stat_q & ~pwdata[FCSIR_SRC_NUM-1:0]) | src_evt;
    end else begin
      stat_q <= stat_q | src_evt;
    end
  end

  // Interrupt mask, one bit per source.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= FCSIR_IRQ_MASK_RST;
    end else if (idx == FCSIR_IDX_IRQ_MASK && lo_wr) begin
      mask_q <= pwdata[FCSIR_SRC_NUM-1:0];
    end
  end

  // Fault reporting outputs from flip-flops.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      string_fault <= '0;
      gnd_short    <= 1'b0;
      irq          <= 1'b0;
    end else begin
      string_fault <= string_short & ~cfg_q[FCSIR_STRINGS-1:0];
      gnd_short    <= gnd_short_raw && boost_active && cfg_q[FCSIR_GND_DET_BIT];
      irq          <= |((stat_q | src_evt) & mask_q);
    end
  end

  // Read data registered during setup so it is stable in the access phase.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite && !hit) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      unique case (idx)
        FCSIR_IDX_FAULT_CFG: prdata <= {16'h0000, cfg_q};
        FCSIR_IDX_SUPPLY_EN: prdata <= {18'h00000, src_rd};
        FCSIR_IDX_GLOBAL_EN: prdata <= {24'h000000, glb_rd, 6'h00};
        FCSIR_IDX_IRQ_STAT:  prdata <= {25'h0000000, stat_q};
        FCSIR_IDX_IRQ_MASK:  prdata <= {25'h0000000, mask_q};
        default:             prdata <= '0;
      endcase
    end
  end

  a_gnd_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
    gnd_short |-> $past(cfg_q[FCSIR_GND_DET_BIT]) && $past(gnd_short_raw))
    else $error("Ground short reported while detection off.");
  a_string_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
    ##1 (string_fault == ($past(string_short) & ~$past(cfg_q[3:0]))))
    else $error("String short fault not gated by its disable bit.");
  a_reserved_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    cfg_q[15:9] == 7'h00 && src_rd[0] == 1'b0)
    else $error("Reserved bits or odd code bits read non-zero.");
  a_read_code: assert property (@(posedge core_clk) disable iff (!rst_n)
    src_rd[13:12] == (src_en[6] ? 2'h2 : 2'h0))
    else $error("Boost sync enable reads a wrong code.");
  a_no_disabled_evt: assert property (@(posedge core_clk) disable iff (!rst_n)
    !glb_en |=> ((stat_q & ~$past(stat_q)) == '0))
    else $error("Status set with global enable off.");
  a_sticky_set: assert property (@(posedge core_clk) disable iff (!rst_n)
    (supply_fault[0] && src_en[0] && glb_en) |=> stat_q[0])
    else $error("Enabled fault did not set status.");
  a_masked_src: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!src_en[5] && $past(!src_en[5]) && !$past(stat_q[5])) |-> !stat_q[5])
    else $error("Disabled charge pump fault set status.");
  a_irq_level: assert property (@(posedge core_clk) disable iff (!rst_n)
    |(stat_q & mask_q) |=> irq)
    else $error("Interrupt low with unmasked status set.");

  // The slave never stretches a transfer, so masters need no wait logic.
  a_pready_high: assert property (@(posedge core_clk) disable iff (!rst_n)
    pready == 1'b1)
    else $error("Ready dropped low.");

  // A byte address off a word boundary is refused in the access phase.
  a_slverr_align: assert property (@(posedge core_clk) disable iff (!rst_n)
    (psel && penable && paddr[1:0] != 2'h0) |-> pslverr)
    else $error("Misaligned access not refused.");

  // Refused reads must not leak the contents of a nearby register.
  a_read_unmapped: assert property (@(posedge core_clk) disable iff (!rst_n)
    (psel && !penable && !pwrite && !hit) |=> (prdata == 32'h0000_0000))
    else $error("Unmapped read returned non-zero data.");

  // Status bits only fall on a software clear, never by themselves.
  a_stat_sticky: assert property (@(posedge core_clk) disable iff (!rst_n)
    !(idx == FCSIR_IDX_IRQ_STAT && lo_wr) |=> ((~stat_q & $past(stat_q)) == '0))
    else $error("Status bit cleared without a write.");

  // Configuration changes only through an accepted write.
  a_cfg_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    !wr_acc |=> $stable(cfg_q))
    else $error("Fault configuration changed without a write.");

  // The global field uses the same read codes as the source fields.
  a_glb_read: assert property (@(posedge core_clk) disable iff (!rst_n)
    glb_rd == (glb_en ? 2'h2 : 2'h0))
    else $error("Global enable reads a wrong code.");

  // With detection off, no ground short may reach the output.
  a_gnd_off: assert property (@(posedge core_clk) disable iff (!rst_n)
    !cfg_q[FCSIR_GND_DET_BIT] |=> !gnd_short)
    else $error("Ground short reported while detection off.");

  // A disabled boost sync source cannot newly set its status bit.
  a_sync_off: assert property (@(posedge core_clk) disable iff (!rst_n)
    !src_en[6] |=> !$rose(stat_q[6]))
    else $error("Disabled boost sync fault set status.");

  // With every source masked the interrupt pin stays low.
  a_irq_masked: assert property (@(posedge core_clk) disable iff (!rst_n)
    (mask_q == '0) && $past(mask_q == '0) |-> !irq)
    else $error("Interrupt high with every source masked.");

endmodule : fcsir_regs
`default_nettype wire

// File: verification/tb_top.sv
// Self-checking bench for the fault configuration and supply interrupt enable registers.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import fcsir_pkg::*;
  logic        core_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic        gnd_short_raw, boost_active, gnd_short, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, d;
  logic [3:0]  pstrb, string_short, string_fault;
  logic [6:0]  supply_fault, en;
  logic [32:0] q[$];
  int          err_count, num_checks;

  fcsir_regs u_dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .supply_fault(supply_fault), .string_short(string_short), .gnd_short_raw(gnd_short_raw),
    .boost_active(boost_active), .string_fault(string_fault), .gnd_short(gnd_short), .irq(irq));

  // Free-running 200 MHz core clock.
  always #2.5 core_clk = ~core_clk;

  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic final_report;
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  // One APB transfer; the request is held until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge core_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd; pstrb <= 4'hF;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  // A read notes its expected {pslverr, prdata} before the transfer starts.
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd

  // Writes the supply enable register, updates the model, and reads it back.
  task automatic wr_en(input logic [31:0] wd);
    logic [15:0] r;
    for (int i = 0; i < 7; i++) begin
      if (wd[2*i +: 2] == FCSIR_EN_WR_OFF) en[i] = 1'b0;
      else if (wd[2*i +: 2] == FCSIR_EN_WR_ON) en[i] = 1'b1;
      r[2*i +: 2] = en[i] ? FCSIR_EN_RD_ON : FCSIR_EN_RD_OFF;
    end
    r[15:14] = 2'h0;
    apb(1'b1, 8'h20, wd);
    rd(8'h20, {17'h0, r});
  endtask : wr_en

  task automatic pulse(input int k);
    @(posedge core_clk);
    supply_fault <= 7'h01 << k;
    @(posedge core_clk);
    supply_fault <= 7'h00;
  endtask : pulse

  // Waits two edges so a registered output has settled, then compares it.
  task automatic pin(input logic [32:0] got_sel, input logic [32:0] e);
    repeat (2) @(posedge core_clk);
    #1 cmp(got_sel == 33'h0 ? {32'h0, irq} : {28'h0, gnd_short, string_fault}, e);
  endtask : pin

  // Read results are compared against the oldest note when the access completes.
  always @(posedge core_clk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
      if (q.size() == 0) cmp(33'h1FFFFFFFF, 33'h0);
      else cmp({pslverr, prdata}, q.pop_front());
    end
  end

  // A hang anywhere ends the run as a failure.
  initial begin
    #200000;
    err_count++;
    final_report();
  end

  initial begin
    {rst_n, psel, penable, pwrite, gnd_short_raw, boost_active} = 6'h00;
    paddr = 8'h00; pwdata = 32'h0; pstrb = 4'h0; string_short = 4'h0; supply_fault = 7'h00;
    err_count = 0; num_checks = 0; en = 7'h7F; core_clk = 1'b0;
    void'($urandom(32'h12aedf3d));
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(8'h18, {1'b0, 32'h100});
    rd(8'h20, {1'b0, 32'h2AAA});
    rd(8'h30, {1'b0, 32'h80});
    rd(8'h38, {1'b0, 32'h7F});
    rd(8'h3C, {1'b1, 32'h0});
    rd(8'h19, {1'b1, 32'h0});
    // Every code in every field, then random mixes of codes.
    foreach (d[i]) if (i < 4) wr_en({18'h0, {7{2'(i + 1)}}});
    for (int n = 0; n < 12; n++) wr_en($urandom & 32'h3FFF);
    wr_en(32'h3FFF);
    // Random configurations with reserved bits written as zero; fault outputs follow them.
    for (int n = 0; n < 16; n++) begin
      d = $urandom & 32'h10F;
      apb(1'b1, 8'h18, d);
      rd(8'h18, {1'b0, d});
      string_short <= 4'($urandom); gnd_short_raw <= 1'($urandom); boost_active <= 1'($urandom);
      @(posedge core_clk);
      #1 cmp({28'h0, gnd_short_raw & boost_active & d[8], string_short & ~d[3:0]}, 33'h0 |
        {28'h0, gnd_short, string_fault});
    end
    // Each source latches, raises irq, is masked, then cleared by a one.
    for (int k = 0; k < 7; k++) begin
      pulse(k);
      rd(8'h34, {1'b0, 32'h1 << k});
      pin(33'h0, 33'h1);
      apb(1'b1, 8'h38, 32'h0);
      pin(33'h0, 33'h0);
      apb(1'b1, 8'h38, 32'h7F);
      pin(33'h0, 33'h1);
      apb(1'b1, 8'h34, 32'h1 << k);
      pin(33'h0, 33'h0);
    end
    // A disabled source and a disabled global enable both keep status clear.
    wr_en(32'h1);
    pulse(0);
    rd(8'h34, {1'b0, 32'h0});
    wr_en(32'h3);
    apb(1'b1, 8'h30, 32'h40);
    rd(8'h30, {1'b0, 32'h0});
    pulse(1);
    rd(8'h34, {1'b0, 32'h0});
    pin(33'h0, 33'h0);
    apb(1'b1, 8'h30, 32'hC0);
    rd(8'h30, {1'b0, 32'h80});
    repeat (4) @(posedge core_clk);
    final_report();
  end
endmodule : tb_top
`default_nettype wire
